//--- spi_ef_consts.svh
`ifndef SPI_EF_CONSTS_SVH
`define SPI_EF_CONSTS_SVH

// Register byte offsets
`define SPI_EF_OFS_CTRL      12'h000
`define SPI_EF_OFS_CHARS     12'h004
`define SPI_EF_OFS_LEVELS    12'h01C
`define SPI_EF_OFS_FLAGS     12'h020

// Widths
`define SPI_EF_ADDR_W        12
`define SPI_EF_LVL_W         6
`define SPI_EF_THD_W         5
`define SPI_EF_CHAR_W        16

// Event flag bit positions
`define SPI_EF_BIT_RECEIVE_UNDERRUN_FLAG     15
`define SPI_EF_BIT_RECEIVE_OVERRUN_FLAG     14
`define SPI_EF_BIT_TRANSMIT_UNDERRUN_FLAG     13
`define SPI_EF_BIT_TRANSMIT_OVERRUN_FLAG     12
`define SPI_EF_BIT_DONE      11
`define SPI_EF_BIT_ABORT     9
`define SPI_EF_BIT_FAULT     8
`define SPI_EF_BIT_SSD       5
`define SPI_EF_BIT_SSA       4
`define SPI_EF_BIT_RX_FULL   3
`define SPI_EF_BIT_RX_THD    2
`define SPI_EF_BIT_TRANSMIT_EMPTY_FLAG     1
`define SPI_EF_BIT_TX_THD    0

// Implemented flag bits; the rest read as zero
`define SPI_EF_FLAG_MASK     32'h0000FB3F
`define SPI_EF_FLAGS_RST     32'h00000002

// Control register fields
`define SPI_EF_CTRL_MODE     0
`define SPI_EF_CTRL_MM_EN    1

// Threshold and level register fields
`define SPI_EF_RX_THD_LSB    16
`define SPI_EF_TX_THD_LSB    0
`define SPI_EF_RX_LVL_LSB    24
`define SPI_EF_TX_LVL_LSB    8
`define SPI_EF_RX_THD_RST    5'h00
`define SPI_EF_TX_THD_RST    5'h10

// Bits per character
`define SPI_EF_BIT_CNT_W     3
`define SPI_EF_LAST_BIT      3'h7

`endif

//--- spi_ef_pkg.sv
`include "spi_ef_consts.svh"

package spi_ef_pkg;

  // APB request from the master
  typedef struct packed {
    logic                       psel;
    logic                       penable;
    logic                       pwrite;
    logic [`SPI_EF_ADDR_W-1:0]  paddr;
    logic [31:0]                pwdata;
  } spi_ef_apb_req_t;

  // APB answer to the master
  typedef struct packed {
    logic                       pready;
    logic                       pslverr;
    logic [31:0]                prdata;
  } spi_ef_apb_rsp_t;

  // Queue state from the FIFOs, core clock domain
  typedef struct packed {
    logic [`SPI_EF_LVL_W-1:0]   rx_level;
    logic [`SPI_EF_LVL_W-1:0]   tx_level;
    logic                       rx_read;
    logic                       tx_write;
  } spi_ef_fifo_t;

  // Shifter events, one bit each, link clock domain
  typedef struct packed {
    logic                       bit_done;
    logic                       rx_push;
    logic                       tx_pull;
    logic                       collision;
  } spi_ef_link_ev_t;

endpackage

//--- spi_ef_link.sv
`timescale 1ns/1ps

// Turns link-domain event pulses into toggles for the core domain
module spi_ef_link (
  input  wire logic                        link_clk,
  input  wire logic                        rst_n,
  input  wire spi_ef_pkg::spi_ef_link_ev_t ev,
  output spi_ef_pkg::spi_ef_link_ev_t      ev_tog
);
  import spi_ef_pkg::*;

  spi_ef_link_ev_t tog_reg;   // Toggle per event
  spi_ef_link_ev_t tog_next;  // Next toggle state

  // Each event flips its own toggle
  assign tog_next = tog_reg ^ ev;
  assign ev_tog   = tog_reg;

  // Toggle registers on the link clock
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      tog_reg <= '0;
    end else begin
      tog_reg <= tog_next;
    end
  end

endmodule

//--- spi_ef_top.sv
`timescale 1ns/1ps
`include "spi_ef_consts.svh"

module spi_ef_top #(
  parameter int FIFO_DEPTH = 32
) (
  input  wire logic                        core_clk,
  input  wire logic                        rst_n,
  input  wire logic                        link_clk,
  input  wire spi_ef_pkg::spi_ef_apb_req_t apb_req,
  output spi_ef_pkg::spi_ef_apb_rsp_t      apb_rsp,
  input  wire spi_ef_pkg::spi_ef_fifo_t    fifo,
  input  wire spi_ef_pkg::spi_ef_link_ev_t link_ev,
  input  wire logic                        ss_in_n,
  output logic                             ctrl_mode,
  output logic                             mm_enable,
  output logic [`SPI_EF_THD_W-1:0]         rx_thd_val,
  output logic [`SPI_EF_THD_W-1:0]         tx_thd_val,
  output logic                             sclk_stall,
  output logic                             rx_dma_req,
  output logic                             tx_dma_req,
  output logic [31:0]                      event_flags
);
  import spi_ef_pkg::*;

  localparam int LW = `SPI_EF_LVL_W;

  // Depth must fit the level fields; a depth at or above 2**LW would
  // make the full compare unreachable, so elaboration stops here
  if (FIFO_DEPTH < 1 || FIFO_DEPTH >= (1 << LW)) begin : g_depth_chk
    $error("FIFO_DEPTH out of range for level width");
  end

  localparam logic [LW-1:0] DEPTH_LVL = LW'(FIFO_DEPTH);

  // ---------------------------------------------------------------
  // Link domain: events become toggles
  // ---------------------------------------------------------------
  spi_ef_link_ev_t ev_tog;            // Toggles from the link domain
  spi_ef_link_ev_t tog_meta_reg;      // First synchroniser stage
  spi_ef_link_ev_t tog_sync_reg;      // Second synchroniser stage
  spi_ef_link_ev_t tog_prev_reg;      // Delayed copy for edge detect
  spi_ef_link_ev_t ev_pulse;          // One-cycle events, core domain

  spi_ef_link u_link (
    .link_clk (link_clk),
    .rst_n    (rst_n),
    .ev       (link_ev),
    .ev_tog   (ev_tog)
  );

  // A toggle moves once per event, so each bit crosses on its own
  // Two events closer than one core cycle would cancel out and both be lost
  // Toggle synchronisers, one per event bit
  genvar gi;
  generate
    for (gi = 0; gi < $bits(spi_ef_link_ev_t); gi++) begin : g_sync
      // Two stages then a delayed copy
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          tog_meta_reg[gi] <= 1'b0;
          tog_sync_reg[gi] <= 1'b0;
          tog_prev_reg[gi] <= 1'b0;
        end else begin
          tog_meta_reg[gi] <= ev_tog[gi];
          tog_sync_reg[gi] <= tog_meta_reg[gi];
          tog_prev_reg[gi] <= tog_sync_reg[gi];
        end
      end
    end
  endgenerate

  // A change of toggle is one event
  assign ev_pulse = tog_sync_reg ^ tog_prev_reg;

  // ---------------------------------------------------------------
  // Target-select pin synchroniser
  // ---------------------------------------------------------------
  logic ss_meta_reg;   // First stage
  logic ss_sync_reg;   // Second stage, safe to read
  logic ss_prev_reg;   // Previous synchronised level

  // Pin passes two flops; idle level is released
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ss_meta_reg <= 1'b1;
      ss_sync_reg <= 1'b1;
      ss_prev_reg <= 1'b1;
    end else begin
      ss_meta_reg <= ss_in_n;
      ss_sync_reg <= ss_meta_reg;
      ss_prev_reg <= ss_sync_reg;
    end
  end

  wire ss_assert_edge  = ss_prev_reg & ~ss_sync_reg;  // Falling pin
  wire ss_release_edge = ~ss_prev_reg & ss_sync_reg;  // Rising pin
  wire ss_active       = ~ss_sync_reg;                // Select held

  // ---------------------------------------------------------------
  // APB slave decode
  // ---------------------------------------------------------------
  logic [31:0]               prdata_reg;    // Read data
  logic                      pready_reg;    // Ready in access phase
  logic                      pslverr_reg;   // Unmapped address
  logic [31:0]               prdata_next;   // Read data to capture
  logic                      ctrl_mode_reg; // 1 = controller
  logic                      mm_en_reg;     // Multi-controller enable
  logic [`SPI_EF_THD_W-1:0]  rx_thd_reg;    // Receive threshold
  logic [`SPI_EF_THD_W-1:0]  tx_thd_reg;    // Transmit threshold
  logic [`SPI_EF_CHAR_W-1:0] char_num_reg;  // Programmed char count
  logic [31:0]               flags_reg;     // Event flag register
  logic [31:0]               flags_next;    // Next flag value

  // Zero wait states: pready rises in the first access cycle
  wire apb_setup  = apb_req.psel & ~apb_req.penable;
  wire apb_access = apb_req.psel & apb_req.penable & pready_reg;
  wire apb_wr     = apb_access & apb_req.pwrite;

  wire sel_ctrl   = apb_req.paddr == `SPI_EF_OFS_CTRL;
  wire sel_chars  = apb_req.paddr == `SPI_EF_OFS_CHARS;
  wire sel_levels = apb_req.paddr == `SPI_EF_OFS_LEVELS;
  wire sel_flags  = apb_req.paddr == `SPI_EF_OFS_FLAGS;
  wire sel_any    = sel_ctrl | sel_chars | sel_levels | sel_flags;

  wire wr_ctrl    = apb_wr & sel_ctrl;
  wire wr_chars   = apb_wr & sel_chars;
  wire wr_levels  = apb_wr & sel_levels;
  wire wr_flags   = apb_wr & sel_flags;

  // Read mux; reserved bits are zero
  wire [31:0] rd_ctrl   = {30'h0, mm_en_reg, ctrl_mode_reg};
  wire [31:0] rd_chars  = {16'h0, char_num_reg};
  wire [31:0] rd_levels = {2'h0, fifo.rx_level, 3'h0, rx_thd_reg,
                           2'h0, fifo.tx_level, 3'h0, tx_thd_reg};
  assign prdata_next = sel_ctrl   ? rd_ctrl   :
                       sel_chars  ? rd_chars  :
                       sel_levels ? rd_levels :
                       sel_flags  ? flags_reg : 32'h0000_0000;

  // Answer is captured in setup, shown in the access phase
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else begin
      pready_reg  <= apb_setup;
      pslverr_reg <= apb_setup & ~sel_any;
      prdata_reg  <= apb_setup ? prdata_next : 32'h0000_0000;
    end
  end

  // Control, count and threshold registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_mode_reg <= 1'b0;
      mm_en_reg     <= 1'b0;
      char_num_reg  <= 16'h0000;
      rx_thd_reg    <= `SPI_EF_RX_THD_RST;
      tx_thd_reg    <= `SPI_EF_TX_THD_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_mode_reg <= apb_req.pwdata[`SPI_EF_CTRL_MODE];
        mm_en_reg     <= apb_req.pwdata[`SPI_EF_CTRL_MM_EN];
      end
      if (wr_chars) begin
        char_num_reg <= apb_req.pwdata[`SPI_EF_CHAR_W-1:0];
      end
      if (wr_levels) begin
        rx_thd_reg <= apb_req.pwdata[`SPI_EF_RX_THD_LSB +: `SPI_EF_THD_W];
        tx_thd_reg <= apb_req.pwdata[`SPI_EF_TX_THD_LSB +: `SPI_EF_THD_W];
      end
    end
  end

  // ---------------------------------------------------------------
  // Queue conditions
  // ---------------------------------------------------------------
  wire rx_empty = fifo.rx_level == '0;
  wire rx_full  = fifo.rx_level == DEPTH_LVL;
  wire tx_empty = fifo.tx_level == '0;
  wire tx_full  = fifo.tx_level == DEPTH_LVL;

  wire [LW-1:0] rx_thd_lvl = {1'b0, rx_thd_reg};
  wire [LW-1:0] tx_thd_lvl = {1'b0, tx_thd_reg};
  wire rx_above = fifo.rx_level > rx_thd_lvl;  // Sets receive flag
  wire rx_below = fifo.rx_level < rx_thd_lvl;  // Clears receive flag
  wire tx_below = fifo.tx_level < tx_thd_lvl;  // Sets transmit flag
  wire tx_above = fifo.tx_level > tx_thd_lvl;  // Clears transmit flag

  // ---------------------------------------------------------------
  // Bit and character tracking
  // ---------------------------------------------------------------
  logic [`SPI_EF_BIT_CNT_W-1:0] bit_cnt_reg;   // Bits in this char
  logic [`SPI_EF_CHAR_W-1:0]    chars_reg;     // Chars since start
  logic [`SPI_EF_CHAR_W-1:0]    chars_inc;     // Count plus one

  wire char_done = ev_pulse.bit_done & (bit_cnt_reg == `SPI_EF_LAST_BIT);
  assign chars_inc = chars_reg + 16'h0001;
  wire count_hit = ctrl_mode_reg & char_done & (char_num_reg != '0) &
                   (chars_inc == char_num_reg);

  // Bit counter restarts on each select assertion
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_reg <= '0;
    end else if (ss_assert_edge) begin
      bit_cnt_reg <= '0;
    end else if (ev_pulse.bit_done) begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
    end
  end

  // Character counter restarts when a new count is written
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      chars_reg <= '0;
    end else if (wr_chars || count_hit) begin
      chars_reg <= '0;
    end else if (ctrl_mode_reg && char_done) begin
      chars_reg <= chars_inc;
    end
  end

  // ---------------------------------------------------------------
  // Event flags
  // ---------------------------------------------------------------
  logic [31:0] set_vec;   // Hardware sets this cycle
  logic [31:0] clr_vec;   // Clears this cycle

  wire ev_receive_underrun_flag  = fifo.rx_read & rx_empty;
  wire ev_receive_overrun_flag  = ev_pulse.rx_push & rx_full;
  wire ev_transmit_underrun_flag  = ~ctrl_mode_reg & ev_pulse.tx_pull
                   & tx_empty;
  wire ev_transmit_overrun_flag  = fifo.tx_write & tx_full;
  wire ev_done   = count_hit & tx_empty;
  // Abort needs a partial character: bit counter not at zero
  wire ev_abort  = ~ctrl_mode_reg & ss_release_edge
                   & (bit_cnt_reg != '0);
  wire ev_fault  = ctrl_mode_reg & mm_en_reg
                   & (ss_assert_edge | ev_pulse.collision);

  // Level flags re-set every cycle their condition holds, so a
  // write-one clear only sticks once the condition has gone
  // Collected set terms by bit position
  always_comb begin
    set_vec = 32'h0000_0000;
    set_vec[`SPI_EF_BIT_RECEIVE_UNDERRUN_FLAG]   = ev_receive_underrun_flag;
    set_vec[`SPI_EF_BIT_RECEIVE_OVERRUN_FLAG]   = ev_receive_overrun_flag;
    set_vec[`SPI_EF_BIT_TRANSMIT_UNDERRUN_FLAG]   = ev_transmit_underrun_flag;
    set_vec[`SPI_EF_BIT_TRANSMIT_OVERRUN_FLAG]   = ev_transmit_overrun_flag;
    set_vec[`SPI_EF_BIT_DONE]    = ev_done;
    set_vec[`SPI_EF_BIT_ABORT]   = ev_abort;
    set_vec[`SPI_EF_BIT_FAULT]   = ev_fault | (ctrl_mode_reg & mm_en_reg
                                   & ss_active & ss_assert_edge);
    set_vec[`SPI_EF_BIT_SSD]     = ss_release_edge;
    set_vec[`SPI_EF_BIT_SSA]     = ss_assert_edge;
    set_vec[`SPI_EF_BIT_RX_FULL] = rx_full;
    set_vec[`SPI_EF_BIT_RX_THD]  = rx_above;
    set_vec[`SPI_EF_BIT_TRANSMIT_EMPTY_FLAG]   = tx_empty;
    set_vec[`SPI_EF_BIT_TX_THD]  = tx_below;
  end

  // Software write-one clears plus level-driven clears
  always_comb begin
    clr_vec = wr_flags ? apb_req.pwdata : 32'h0000_0000;
    clr_vec[`SPI_EF_BIT_RX_THD] = clr_vec[`SPI_EF_BIT_RX_THD]
                                  | rx_below;
    clr_vec[`SPI_EF_BIT_TX_THD] = clr_vec[`SPI_EF_BIT_TX_THD]
                                  | tx_above;
  end

  // Set wins over clear; sticky until cleared
  assign flags_next = ((flags_reg & ~clr_vec) | set_vec)
                      & `SPI_EF_FLAG_MASK;

  // Flag register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_reg <= `SPI_EF_FLAGS_RST;
    end else begin
      flags_reg <= flags_next;
    end
  end

  // ---------------------------------------------------------------
  // Clock stall and DMA requests
  // ---------------------------------------------------------------
  logic stall_reg;    // Controller clock stall
  logic rx_dma_reg;   // Receive DMA request
  logic tx_dma_reg;   // Transmit DMA request

  // Stall follows the queues one cycle late; shifter must allow it
  wire stall_next = ctrl_mode_reg & (rx_full | tx_empty);

  // Registered so each output comes from a flop
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stall_reg  <= 1'b0;
      rx_dma_reg <= 1'b0;
      tx_dma_reg <= 1'b0;
    end else begin
      stall_reg  <= stall_next;
      rx_dma_reg <= rx_above;
      tx_dma_reg <= tx_below;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign apb_rsp.pready  = pready_reg;
  assign apb_rsp.pslverr = pslverr_reg;
  assign apb_rsp.prdata  = prdata_reg;
  assign ctrl_mode       = ctrl_mode_reg;
  assign mm_enable       = mm_en_reg;
  assign rx_thd_val      = rx_thd_reg;
  assign tx_thd_val      = tx_thd_reg;
  assign sclk_stall      = stall_reg;
  assign rx_dma_req      = rx_dma_reg;
  assign tx_dma_req      = tx_dma_reg;
  assign event_flags     = flags_reg;

endmodule

//--- spi_ef_properties.sv
`timescale 1ns/1ps
`include "spi_ef_consts.svh"

// Port-level checks on the event flag block
module spi_ef_props #(
  parameter int FIFO_DEPTH = 32
) (
  input wire logic                        core_clk,
  input wire logic                        rst_n,
  input wire spi_ef_pkg::spi_ef_apb_req_t apb_req,
  input wire spi_ef_pkg::spi_ef_fifo_t    fifo,
  input wire logic                        ctrl_mode,
  input wire logic                        mm_enable,
  input wire logic [`SPI_EF_THD_W-1:0]    rx_thd_val,
  input wire logic [`SPI_EF_THD_W-1:0]    tx_thd_val,
  input wire logic                        sclk_stall,
  input wire logic [31:0]                 event_flags
);
  import spi_ef_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Write access to the flag register
  wire flag_wr = apb_req.psel && apb_req.penable && apb_req.pwrite
                 && apb_req.paddr == `SPI_EF_OFS_FLAGS;
  // Receive queue at capacity
  wire q_full  = fifo.rx_level == FIFO_DEPTH;

  a_rx_underrun: assert property (fifo.rx_read && fifo.rx_level == 0
    |-> ##[1:2] event_flags[15]) else $error("rx underrun not set");
  a_tx_overrun: assert property (fifo.tx_write
    && fifo.tx_level == FIFO_DEPTH
    |-> ##[1:2] event_flags[12]) else $error("tx overrun not set");
  a_rx_full_set: assert property (q_full [*2] |-> event_flags[3])
    else $error("rx full not set");
  a_rx_thd_set: assert property ((fifo.rx_level > rx_thd_val) [*2]
    |-> event_flags[2]) else $error("rx threshold not set");
  a_tx_thd_clr: assert property ((fifo.tx_level > tx_thd_val) [*2]
    |-> !event_flags[0]) else $error("tx threshold not cleared");
  a_stall_full: assert property ((ctrl_mode && q_full) [*2]
    |-> sclk_stall) else $error("no stall on full queue");
  a_stall_mode: assert property (sclk_stall |-> $past(ctrl_mode))
    else $error("stall outside controller mode");
  a_sticky_ev: assert property (|($past(event_flags[15:8])
    & ~event_flags[15:8]) |-> $past(flag_wr)) else $error("flag lost");
  a_rsvd_zero: assert property ((event_flags & 32'hFFFF04C0) == 32'h0)
    else $error("reserved bit set");
  a_fault_mode: assert property ($rose(event_flags[8])
    |-> $past(ctrl_mode && mm_enable)) else $error("fault out of mode");
  a_transmit_underrun_flag_tgt: assert property ($rose(event_flags[13])
    |-> !$past(ctrl_mode)) else $error("tx underrun in controller");
  a_done_ctrl: assert property ($rose(event_flags[11])
    |-> $past(ctrl_mode)) else $error("done outside controller");
  a_abort_tgt: assert property ($rose(event_flags[9])
    |-> !$past(ctrl_mode)) else $error("abort outside target");
  c_flag_wr: cover property (flag_wr);
  c_stall: cover property (sclk_stall);
  c_abort: cover property ($rose(event_flags[9]));
  c_done: cover property ($rose(event_flags[11]));
  c_fault: cover property ($rose(event_flags[8]));
endmodule

bind spi_ef_top spi_ef_props #(.FIFO_DEPTH(FIFO_DEPTH)) i_spi_ef_props (
  .core_clk, .rst_n, .apb_req, .fifo, .ctrl_mode, .mm_enable,
  .rx_thd_val, .tx_thd_val, .sclk_stall, .event_flags);

//--- spi_ef_far.sv
`timescale 1ns/1ps

// Far-side model: select line, framed link clock, shifter events
module spi_ef_far (
  output logic                        link_clk,
  output spi_ef_pkg::spi_ef_link_ev_t link_ev,
  output logic                        ss_in_n
);
  import spi_ef_pkg::*;
  // Idle: clock parked low, select released, no events
  initial begin
    link_clk = 1'b0;
    link_ev  = '0;
    ss_in_n  = 1'b1;
  end
  // One select frame of nb bits; ev rides on every 8th bit
  task automatic frame(input int nb, input logic [2:0] ev);
    #203.3;
    ss_in_n = 1'b0;
    for (int i = 0; i < nb; i++) begin
      #40 link_clk = 1'b1;
      #1 link_ev = {1'b1, (i % 8 == 7) ? ev : 3'b000};
      #39 link_clk = 1'b0;
    end
    #40 link_clk = 1'b1;
    #1 link_ev = '0;
    #39 link_clk = 1'b0;
    #200 ss_in_n = 1'b1;
    #400;
  endtask
endmodule

//--- spi_ef_tb_top.sv
`timescale 1ns/1ps
`include "spi_ef_consts.svh"

// Self-checking bench for the event flag block
module spi_ef_tb_top;
  import spi_ef_pkg::*;
  logic            core_clk, rst_n, link_clk, ss_in_n;
  spi_ef_apb_req_t apb_req;
  spi_ef_apb_rsp_t apb_rsp;
  spi_ef_fifo_t    fifo;
  spi_ef_link_ev_t link_ev;
  logic            ctrl_mode, mm_enable, sclk_stall;
  logic            rx_dma_req, tx_dma_req, rerr;
  logic [4:0]      rx_thd_val, tx_thd_val;
  logic [31:0]     event_flags, rdat;
  int              mismatches, n_compared;

  spi_ef_top i_spi_ef_top (.core_clk, .rst_n, .link_clk, .apb_req,
    .apb_rsp, .fifo, .link_ev, .ss_in_n, .ctrl_mode, .mm_enable,
    .rx_thd_val, .tx_thd_val, .sclk_stall, .rx_dma_req, .tx_dma_req,
    .event_flags);
  spi_ef_far i_spi_ef_far (.link_clk, .link_ev, .ss_in_n);

  // Core clock, 5 ns
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // Compare and count
  task automatic chk(input string nm, input logic [31:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  // One APB transfer, bounded wait for pready
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    apb_req <= '{1'b1, 1'b0, w, a, d};
    @(posedge core_clk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 16);
    if (apb_rsp.pready !== 1'b1) begin
      mismatches++;
      end_sim();
    end
    rdat = apb_rsp.prdata;
    rerr = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask
  task automatic rd_flags(input logic [31:0] exp);
    apb(1'b0, `SPI_EF_OFS_FLAGS, 32'h0);
    chk("flags", rdat, exp);
  endtask
  task automatic clr();
    apb(1'b1, `SPI_EF_OFS_FLAGS, 32'hFFFFFFFF);
  endtask
  task automatic lvl(input logic [5:0] rx, tx);
    @(posedge core_clk);
    fifo.rx_level <= rx;
    fifo.tx_level <= tx;
    repeat (4) @(posedge core_clk);
  endtask
  // Reset state, write-one clear, unmapped access
  task automatic t_reset();
    chk("thd rst", {22'h0, rx_thd_val, tx_thd_val}, 32'h10);
    rd_flags(32'h00000003);
    clr();
    rd_flags(32'h00000003);
    apb(1'b0, 12'h040, 32'h0);
    chk("unmapped err", {31'h0, rerr}, 32'h1);
    chk("unmapped data", rdat, 32'h0);
    $display("test reset done");
  endtask
  // Queue underrun, overrun, full and thresholds
  task automatic t_fifo();
    @(posedge core_clk);
    fifo <= '{6'h00, 6'h20, 1'b1, 1'b1};
    @(posedge core_clk);
    fifo <= '{6'h20, 6'h14, 1'b0, 1'b0};
    repeat (4) @(posedge core_clk);
    apb(1'b1, `SPI_EF_OFS_FLAGS, 32'h0);
    rd_flags(32'h0000900E);
    chk("rx dma", {31'h0, rx_dma_req}, 32'h1);
    chk("tx dma", {31'h0, tx_dma_req}, 32'h0);
    clr();
    rd_flags(32'h0000000C);
    $display("test fifo done");
  endtask
  // Programmed thresholds, level readback, crossings both ways
  task automatic t_thd();
    apb(1'b1, `SPI_EF_OFS_LEVELS, 32'h0004_0008);
    lvl(6'h05, 6'h07);
    chk("rx thd", {27'h0, rx_thd_val}, 32'h4);
    chk("tx thd", {27'h0, tx_thd_val}, 32'h8);
    chk("tx dma on", {31'h0, tx_dma_req}, 32'h1);
    apb(1'b0, `SPI_EF_OFS_LEVELS, 32'h0);
    chk("levels", rdat, 32'h0504_0708);
    clr();
    rd_flags(32'h00000005);
    lvl(6'h03, 6'h09);
    rd_flags(32'h00000000);
    apb(1'b1, `SPI_EF_OFS_LEVELS, 32'h0000_0010);
    $display("test threshold done");
  endtask
  // Controller: stalls, done, fault, no tx underrun
  task automatic t_ctrl();
    apb(1'b1, `SPI_EF_OFS_CTRL, 32'h3);
    apb(1'b1, `SPI_EF_OFS_CHARS, 32'h1);
    lvl(6'h20, 6'h05);
    chk("stall full", {31'h0, sclk_stall}, 32'h1);
    chk("mode", {30'h0, mm_enable, ctrl_mode}, 32'h3);
    lvl(6'h00, 6'h00);
    chk("stall empty", {31'h0, sclk_stall}, 32'h1);
    lvl(6'h00, 6'h05);
    chk("no stall", {31'h0, sclk_stall}, 32'h0);
    lvl(6'h00, 6'h00);
    clr();
    rd_flags(32'h00000003);
    i_spi_ef_far.frame(8, 3'b011);
    rd_flags(32'h00000933);
    clr();
    $display("test controller done");
  endtask
  // Target: aborted frame, then full frame with queue faults
  task automatic t_target();
    apb(1'b1, `SPI_EF_OFS_CTRL, 32'h0);
    i_spi_ef_far.frame(5, 3'b000);
    chk("mode tgt", {30'h0, mm_enable, ctrl_mode}, 32'h0);
    rd_flags(32'h00000233);
    clr();
    lvl(6'h20, 6'h00);
    i_spi_ef_far.frame(8, 3'b110);
    rd_flags(32'h0000603F);
    $display("test target done");
  endtask
  // Counts and verdict
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    rst_n = 1'b0;
    apb_req = '0;
    fifo = '0;
    mismatches = 0;
    n_compared = 0;
    repeat (8) @(posedge core_clk);
    chk("reset flags", event_flags, 32'h00000002);
    rst_n <= 1'b1;
    t_reset();
    t_fifo();
    t_thd();
    t_ctrl();
    t_target();
    end_sim();
  end
  // Watchdog
  initial begin
    #50000;
    mismatches++;
    end_sim();
  end
endmodule
